// file: rail_seq_pkg.sv
package rail_seq_pkg;
    // Clock rate and qualification intervals
    localparam int unsigned CLK_HZ        = 50000000;
    localparam int unsigned LONG_QUAL_MS  = 190;
    localparam int unsigned SHORT_QUAL_US = 30;
    // Long interval as a whole cycle count, clamped to at least one
    localparam int unsigned LONG_QUAL_CYC =
        (LONG_QUAL_MS * (CLK_HZ / 1000) + 0) < 1 ? 1 : LONG_QUAL_MS * (CLK_HZ / 1000);
    localparam int unsigned SHORT_QUAL_CYC =
        (SHORT_QUAL_US * (CLK_HZ / 1000000)) < 1 ? 1 : SHORT_QUAL_US * (CLK_HZ / 1000000);
    localparam int unsigned CNT_W = 24;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_ONE_EN,
        ST_TWO_EN,
        ST_THREE_EN,
        ST_POWER_GOOD
    } seq_state_t;
endpackage

// file: qual_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts cycles while a condition holds; restarts on any drop
module qual_timer (
    input  wire logic                         clk,
    input  wire logic                         arst_n,
    input  wire logic                         cond,
    input  wire logic                         restart,
    input  wire logic [rail_seq_pkg::CNT_W-1:0] target,
    output logic                              done
);
    logic [rail_seq_pkg::CNT_W-1:0] count_reg;

    // Saturating counter, cleared on a dropped condition or state change
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
        end else if (!cond || restart) begin
            count_reg <= '0;
        end else if (count_reg < target) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Restart is left out: it is derived from done and would close a combinational loop
    assign done = cond && (count_reg + 1'b1 >= target);
endmodule
`default_nettype wire

// file: four_rail_power_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - In reset all outputs are low and the first enable comes after main rail is high 190 ms.
// - With one enable on, rails main and b high for 30 us raise the second enable.
// - With two enables on, rails main, b and c high for 30 us raise the third enable.
// - With three enables on, all four rails high for 190 ms raise power-good.
// - Power-good is only ever high while all three enables are high.
// - In power-good, rail b, c or d low for 30 us drops power-good back to three enables.
// - A later-rail fault keeps all three enables on and drops only power-good.
// - A main rail fault in power-good drops power-good and every enable at once.
// - Only in power-good does the core supervise and handle falling rails as faults.
module four_rail_power_sequencer #(
    parameter int unsigned LONG_CYC  = rail_seq_pkg::LONG_QUAL_CYC,
    parameter int unsigned SHORT_CYC = rail_seq_pkg::SHORT_QUAL_CYC
) (
    input  wire logic CLK,
    input  wire logic ARST_N,
    input  wire logic MAIN_RAIL_OK_IN,
    input  wire logic RAIL_B_OK_IN,
    input  wire logic RAIL_C_OK_IN,
    input  wire logic RAIL_D_OK_IN,
    output logic      REG_A_ENABLE_OUT,
    output logic      REG_B_ENABLE_OUT,
    output logic      REG_C_ENABLE_OUT,
    output logic      SYSTEM_POWER_GOOD_OUT
);
    // Intervals are overridable only so a bench can shorten them; silicon keeps defaults
    localparam logic [rail_seq_pkg::CNT_W-1:0] LONG_T =
        rail_seq_pkg::CNT_W'(LONG_CYC);
    localparam logic [rail_seq_pkg::CNT_W-1:0] SHORT_T =
        rail_seq_pkg::CNT_W'(SHORT_CYC);

    logic [3:0]                     rail_meta_reg;
    logic [3:0]                     rail_reg;
    rail_seq_pkg::seq_state_t       state_reg;
    rail_seq_pkg::seq_state_t       state_next;
    logic                           state_change;
    logic                           qual_cond;
    logic [rail_seq_pkg::CNT_W-1:0] qual_target;
    logic                           qual_done;
    logic                           main_ok;
    logic                           later_fault;

    // Comparator results come from pins, so two flops first
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rail_meta_reg <= 4'h0;
            rail_reg      <= 4'h0;
        end else begin
            rail_meta_reg <= {RAIL_D_OK_IN, RAIL_C_OK_IN, RAIL_B_OK_IN, MAIN_RAIL_OK_IN};
            rail_reg      <= rail_meta_reg;
        end
    end

    assign main_ok     = rail_reg[0];
    assign later_fault = !(rail_reg[1] && rail_reg[2] && rail_reg[3]);

    // Select what must hold and for how long in each state
    always_comb begin
        qual_cond   = 1'b0;
        qual_target = LONG_T;
        case (state_reg)
            rail_seq_pkg::ST_RESET: begin
                qual_cond   = main_ok;
                qual_target = LONG_T;
            end
            rail_seq_pkg::ST_ONE_EN: begin
                qual_cond   = &rail_reg[1:0];
                qual_target = SHORT_T;
            end
            rail_seq_pkg::ST_TWO_EN: begin
                qual_cond   = &rail_reg[2:0];
                qual_target = SHORT_T;
            end
            rail_seq_pkg::ST_THREE_EN: begin
                qual_cond   = &rail_reg;
                qual_target = LONG_T;
            end
            rail_seq_pkg::ST_POWER_GOOD: begin
                // Supervisory mode: the timer now qualifies a fault, not a rise
                qual_cond   = main_ok && later_fault;
                qual_target = SHORT_T;
            end
            default: begin
                qual_cond   = 1'b0;
                qual_target = LONG_T;
            end
        endcase
    end

    assign state_change = (state_next != state_reg);

    // One shared timer; a state change restarts it so no credit carries over
    qual_timer u_qual (
        .clk     (CLK),
        .arst_n  (ARST_N),
        .cond    (qual_cond),
        .restart (state_change),
        .target  (qual_target),
        .done    (qual_done)
    );

    // Sequencing transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rail_seq_pkg::ST_RESET: begin
                if (qual_done) begin
                    state_next = rail_seq_pkg::ST_ONE_EN;
                end
            end
            rail_seq_pkg::ST_ONE_EN: begin
                if (qual_done) begin
                    state_next = rail_seq_pkg::ST_TWO_EN;
                end
            end
            rail_seq_pkg::ST_TWO_EN: begin
                if (qual_done) begin
                    state_next = rail_seq_pkg::ST_THREE_EN;
                end
            end
            rail_seq_pkg::ST_THREE_EN: begin
                if (qual_done) begin
                    state_next = rail_seq_pkg::ST_POWER_GOOD;
                end
            end
            rail_seq_pkg::ST_POWER_GOOD: begin
                // Main rail fault wins and is not filtered
                if (!main_ok) begin
                    state_next = rail_seq_pkg::ST_RESET;
                end else if (qual_done) begin
                    state_next = rail_seq_pkg::ST_THREE_EN;
                end
            end
            default: begin
                state_next = rail_seq_pkg::ST_RESET;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= rail_seq_pkg::ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs registered from the next state, glitch free for enable pins
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_A_ENABLE_OUT      <= 1'b0;
            REG_B_ENABLE_OUT      <= 1'b0;
            REG_C_ENABLE_OUT      <= 1'b0;
            SYSTEM_POWER_GOOD_OUT <= 1'b0;
        end else begin
            REG_A_ENABLE_OUT      <= (state_next != rail_seq_pkg::ST_RESET);
            REG_B_ENABLE_OUT      <= (state_next == rail_seq_pkg::ST_TWO_EN)
                                  || (state_next == rail_seq_pkg::ST_THREE_EN)
                                  || (state_next == rail_seq_pkg::ST_POWER_GOOD);
            REG_C_ENABLE_OUT      <= (state_next == rail_seq_pkg::ST_THREE_EN)
                                  || (state_next == rail_seq_pkg::ST_POWER_GOOD);
            SYSTEM_POWER_GOOD_OUT <= (state_next == rail_seq_pkg::ST_POWER_GOOD);
        end
    end

    sequence main_drop_s;
        (state_reg == rail_seq_pkg::ST_POWER_GOOD) && !main_ok;
    endsequence

    sequence all_off_s;
        !REG_A_ENABLE_OUT && !REG_B_ENABLE_OUT && !REG_C_ENABLE_OUT
            && !SYSTEM_POWER_GOOD_OUT;
    endsequence

    AST_RESET_OUTPUTS_LOW: assert property (@(posedge CLK) disable iff (!ARST_N)
        (state_reg == rail_seq_pkg::ST_RESET) |-> all_off_s)
        else $error("Outputs high in reset state");
    AST_ONE_EN_ONLY_A: assert property (@(posedge CLK) disable iff (!ARST_N)
        (state_reg == rail_seq_pkg::ST_ONE_EN) |-> REG_A_ENABLE_OUT && !REG_B_ENABLE_OUT
            && !REG_C_ENABLE_OUT && !SYSTEM_POWER_GOOD_OUT)
        else $error("First-enable state outputs wrong");
    AST_THIRD_NEEDS_RAILS: assert property (@(posedge CLK) disable iff (!ARST_N)
        $rose(REG_C_ENABLE_OUT) && $past(state_reg) == rail_seq_pkg::ST_TWO_EN
        |-> $past(rail_reg[2]) && $past(rail_reg[1]) && $past(rail_reg[0]))
        else $error("Third enable without its rails");
    AST_PG_NEEDS_ALL: assert property (@(posedge CLK) disable iff (!ARST_N)
        $rose(SYSTEM_POWER_GOOD_OUT) |-> $past(&rail_reg))
        else $error("Power-good without all rails");
    AST_PG_IMPLIES_ENABLES: assert property (@(posedge CLK) disable iff (!ARST_N)
        SYSTEM_POWER_GOOD_OUT |-> REG_A_ENABLE_OUT && REG_B_ENABLE_OUT && REG_C_ENABLE_OUT)
        else $error("Power-good without all enables");
    AST_LATER_FAULT_KEEPS_EN: assert property (@(posedge CLK) disable iff (!ARST_N)
        $fell(SYSTEM_POWER_GOOD_OUT) && $past(main_ok)
            |-> REG_C_ENABLE_OUT && REG_B_ENABLE_OUT && REG_A_ENABLE_OUT)
        else $error("Later fault dropped enables");
    AST_MAIN_FAULT_ALL_OFF: assert property (@(posedge CLK) disable iff (!ARST_N)
        main_drop_s |=> all_off_s)
        else $error("Main fault did not drop all outputs");
    AST_FAULT_RETURNS_RESET: assert property (@(posedge CLK) disable iff (!ARST_N)
        main_drop_s |=> (state_reg == rail_seq_pkg::ST_RESET))
        else $error("Main fault did not return to reset");
    AST_QUAL_RESTART: assert property (@(posedge CLK) disable iff (!ARST_N)
        (state_reg == rail_seq_pkg::ST_ONE_EN) && !rail_reg[1] |=> !REG_B_ENABLE_OUT)
        else $error("Qualification not restarted on drop");
endmodule
`default_nettype wire

// file: rail_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: rail comparators and three regulators driven by the enables
module rail_model (
    input  wire logic        clk,
    input  wire logic [15:0] main_mv,
    input  wire logic        en_a,
    input  wire logic        en_b,
    input  wire logic        en_c,
    input  wire logic [2:0]  rail_fail,
    output logic             main_ok,
    output logic             b_ok,
    output logic             c_ok,
    output logic             d_ok
);
    localparam logic [15:0] REF_MV  = 16'h0258;
    localparam logic [15:0] TOP_MV  = 16'h03E8;
    localparam logic [15:0] STEP_MV = 16'h0032;
    logic [15:0] b_mv = 16'h0000;
    logic [15:0] c_mv = 16'h0000;
    logic [15:0] d_mv = 16'h0000;
    // Regulators ramp while enabled and discharge to zero when off or failed
    always_ff @(posedge clk) begin
        b_mv <= (en_a && !rail_fail[0]) ? (b_mv < TOP_MV ? b_mv + STEP_MV : b_mv) : 16'h0000;
        c_mv <= (en_b && !rail_fail[1]) ? (c_mv < TOP_MV ? c_mv + STEP_MV : c_mv) : 16'h0000;
        d_mv <= (en_c && !rail_fail[2]) ? (d_mv < TOP_MV ? d_mv + STEP_MV : d_mv) : 16'h0000;
    end
    // Comparators: high only strictly above the reference
    assign main_ok = main_mv > REF_MV;
    assign b_ok    = b_mv > REF_MV;
    assign c_ok    = c_mv > REF_MV;
    assign d_ok    = d_mv > REF_MV;
endmodule
`default_nettype wire

// file: test_four_rail_power_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module test_four_rail_power_sequencer;
    // Shortened intervals so every state is reached in a bounded run
    localparam int unsigned TB_LONG   = 2000;
    localparam int unsigned TB_SHORT  = 100;
    localparam int          CYC_LIMIT = 30000;
    logic        clk     = 1'b0;
    logic        arst_n  = 1'b0;
    logic [15:0] main_mv = 16'h0000;
    logic        main_ok, b_ok, c_ok, d_ok;
    logic        en_a, en_b, en_c, pg;
    logic [2:0]  rail_fail = 3'h0;
    logic [3:0]  outs;
    int          errors     = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    // 50 MHz clock
    always #10 clk = ~clk;
    four_rail_power_sequencer #(
        .LONG_CYC  (TB_LONG),
        .SHORT_CYC (TB_SHORT)
    ) dut_u (
        .CLK                   (clk),
        .ARST_N                (arst_n),
        .MAIN_RAIL_OK_IN       (main_ok),
        .RAIL_B_OK_IN          (b_ok),
        .RAIL_C_OK_IN          (c_ok),
        .RAIL_D_OK_IN          (d_ok),
        .REG_A_ENABLE_OUT      (en_a),
        .REG_B_ENABLE_OUT      (en_b),
        .REG_C_ENABLE_OUT      (en_c),
        .SYSTEM_POWER_GOOD_OUT (pg)
    );
    rail_model rail_u (
        .clk     (clk),
        .main_mv (main_mv),
        .en_a    (en_a),
        .en_b    (en_b),
        .en_c    (en_c),
        .rail_fail (rail_fail),
        .main_ok (main_ok),
        .b_ok    (b_ok),
        .c_ok    (c_ok),
        .d_ok    (d_ok)
    );
    // Output pattern, power-good in the top bit
    assign outs = {pg, en_c, en_b, en_a};
    task automatic close_out();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == CYC_LIMIT) begin
            errors++;
            close_out();
        end
    end
    // Power-good never stands without all three enables
    always @(negedge clk) begin
        if (arst_n)
            `CHK(pg & ~(en_a & en_b & en_c), 1'b0)
    end
    // All outputs stay low for the given number of cycles
    task automatic expect_off(input int n);
        repeat (n) begin
            @(negedge clk);
            `CHK({en_a, en_b, en_c, pg}, 4'h0)
        end
    endtask
    // Old pattern must stand for hold cycles, then the new one within extra
    task automatic step_to(input logic [3:0] was, input logic [3:0] want,
                           input int hold, input int extra);
        int n;
        n = 0;
        repeat (hold) begin
            @(negedge clk);
            `CHK(outs, was)
        end
        while (outs !== want && n < extra) begin
            @(negedge clk);
            n++;
        end
        `CHK(outs, want)
    endtask
    // Outputs keep one pattern for the given number of cycles
    task automatic expect_outs(input logic [3:0] want, input int n);
        repeat (n) begin
            @(negedge clk);
            `CHK(outs, want)
        end
    endtask
    // Main rail at, not above, its reference keeps the core idle
    task automatic t_main_below_ref();
        main_mv = 16'h0258;
        expect_off(TB_LONG + 50);
    endtask
    // A main rail dip short of the long interval restarts the wait
    task automatic t_main_short_of_long();
        main_mv = 16'h0CE4;
        expect_off(TB_LONG - 100);
        main_mv = 16'h0000;
        expect_off(10);
        main_mv = 16'h0CE4;
        step_to(4'h0, 4'h1, TB_LONG, 8);
    endtask
    // Each regulator comes up and qualifies the next step
    task automatic t_sequence();
        step_to(4'h1, 4'h3, TB_SHORT, 20);
        step_to(4'h3, 4'h7, TB_SHORT, 20);
        step_to(4'h7, 4'hF, TB_LONG, 20);
    endtask
    // Short dip on rail d is filtered; a long one drops only power-good
    task automatic t_later_fault();
        rail_fail = 3'h4;
        expect_outs(4'hF, 20);
        rail_fail = 3'h0;
        expect_outs(4'hF, TB_SHORT + 40);
        rail_fail = 3'h4;
        step_to(4'hF, 4'h7, TB_SHORT, 8);
        expect_outs(4'h7, 200);
        rail_fail = 3'h0;
        step_to(4'h7, 4'hF, TB_LONG, 20);
    endtask
    // Main rail loss in power-good clears everything, then a fresh start
    task automatic t_main_fault();
        main_mv = 16'h0000;
        step_to(4'hF, 4'h0, 2, 2);
        main_mv = 16'h0CE4;
        step_to(4'h0, 4'h1, TB_LONG, 8);
    endtask
    // Mid-run reset clears outputs; the long wait starts over after release
    task automatic t_mid_reset();
        arst_n = 1'b0;
        expect_off(5);
        arst_n = 1'b1;
        step_to(4'h0, 4'h1, TB_LONG, 8);
    endtask
    // Main sequence, inputs moved on falling edges
    initial begin
        expect_off(20);
        arst_n = 1'b1;
        t_main_below_ref();
        t_main_short_of_long();
        t_sequence();
        t_later_fault();
        t_main_fault();
        t_mid_reset();
        close_out();
    end
endmodule
`default_nettype wire
